// ==== rtl/bdc_burst_counter.v ====
// Two-bit wrapping burst address counter for the burst DRAM controller.
`timescale 1ns/10ps
`default_nettype none
module bdc_burst_counter (
  input  wire       clk,
  input  wire       resetn,
  input  wire       load,
  input  wire       count,
  input  wire [1:0] start_word,
  output reg  [1:0] word_q
);
  // ========================================================================
  // Counter: load takes start plus one, count steps modulo four.
  always @(posedge clk) begin
    if (!resetn) begin
      word_q <= 2'h0;
    end else if (load) begin
      word_q <= start_word + 2'h1;
    end else if (count) begin
      word_q <= word_q + 2'h1;
    end
  end
endmodule // bdc_burst_counter
`default_nettype wire

// ==== rtl/bdc_burst_dram_controller.v ====
// Top level of the burst DRAM controller: refresh, arbitration, burst and watchdog.
`timescale 1ns/10ps
`default_nettype none
`include "bdc_defines.vh"
// How it works
// - Burst moves four words, one row strobe.
// - All logic runs on inverted processor clock.
// - Eight-bit free-running divider, top bit square.
// - Request once per divider-high phase, drop on refresh.
// - Wait with request low until divider low.
// - Decode 01xxxxxxh window qualified by address strobe.
// - Arbitrate in idle, refresh wins.
// - Row strobe, then mux column, then column strobe.
// - Grant access to burst controller.
// - Step burst states, exit on strobe negation.
// - Writes strobe only written byte lanes.
// - Reads strobe every byte lane.
// - Refresh asserts all row and column strobes.
// - Grant raises burst acknowledge to processor.
// - Wait states, then termination when data ready.
// - Burst controller drives counter and mux select.
// - Counter supplies two low column bits.
// - Load start plus one, then increment twice.
// - Eleven-bit multiplexed address, gated by both.
// - Word-zero burst visits offsets 0h through Ch.
// - Watchdog counts divider edges, errors at timeout.
// - Early strobe negation gives no bus error.
// - Renewal states coded 00, 01, 10.
// - Burst read timing 14-7-7-7 clocks.
module bdc_burst_dram_controller #(
  parameter FIRST_CLKS = `BDC_FIRST_CLKS,
  parameter NEXT_CLKS  = `BDC_NEXT_CLKS
) (
  input  wire        CLK,
  input  wire        RESETN,
  input  wire [31:0] ADDR,
  input  wire        AS_N,
  input  wire        RD_WR,
  input  wire [1:0]  SIZE,
  output reg  [3:0]  RAS_N,
  output reg  [3:0]  CAS_N,
  output reg  [10:0] DRAM_ADDR,
  output reg         CBACK_N,
  output reg         STERM_N,
  output reg         BERR_N,
  output reg         RENEWAL_REQUEST
);
  // Processor outputs change on its rising edge, so the block runs on the inverse.
  wire clk = ~CLK;

  localparam [2:0] SQ_IDLE = 3'h0;
  localparam [2:0] SQ_RAS  = 3'h1;
  localparam [2:0] SQ_MUX  = 3'h2;
  localparam [2:0] SQ_CAS  = 3'h3;
  localparam [2:0] SQ_BRST = 3'h4;
  localparam [2:0] SQ_RCAS = 3'h5;
  localparam [2:0] SQ_RRAS = 3'h6;
  localparam [2:0] SQ_DONE = 3'h7;

  localparam [1:0] BC_IDLE = 2'h0;
  localparam [1:0] BC_WAIT = 2'h1;
  localparam [1:0] BC_TERM = 2'h2;
  localparam [1:0] BC_END  = 2'h3;

  localparam [1:0] WD_IDLE = 2'h0;
  localparam [1:0] WD_CNT  = 2'h1;
  localparam [1:0] WD_FLT  = 2'h2;

  // ========================================================================
  // Input synchronisers: strobe and direction come from another clock phase.
  reg as_m_q;
  reg as_q;
  reg rw_m_q;
  reg rw_q;
  always @(posedge clk) begin
    if (!RESETN) begin
      as_m_q <= 1'b0;
      as_q   <= 1'b0;
      rw_m_q <= 1'b1;
      rw_q   <= 1'b1;
    end else begin
      as_m_q <= ~AS_N;
      as_q   <= as_m_q;
      rw_m_q <= RD_WR;
      rw_q   <= rw_m_q;
    end
  end

  // Byte lanes touched by a write of the given size at the given offset.
  function [3:0] lane_mask;
    input [1:0] sz;
    input [1:0] off;
    reg   [3:0] bytes;
    begin
      bytes = 4'h0;
      case (sz)
        2'h1:    bytes = 4'h1;
        2'h2:    bytes = 4'h3;
        2'h3:    bytes = 4'h7;
        default: bytes = 4'hF;
      endcase
      lane_mask = (bytes << off) & 4'hF;
    end
  endfunction

  // ========================================================================
  // Refresh divider.
  reg [`BDC_DIV_WIDTH-1:0] div_q;
  reg                      div7_prev_q;
  always @(posedge clk) begin
    if (!RESETN) begin
      div_q       <= {`BDC_DIV_WIDTH{1'b0}};
      div7_prev_q <= 1'b0;
    end else begin
      div_q       <= div_q + 8'h01;
      div7_prev_q <= div_q[`BDC_DIV_TOP];
    end
  end
  wire div7      = div_q[`BDC_DIV_TOP];
  wire div7_edge = div7 ^ div7_prev_q;

  // ========================================================================
  // Renewal request machine.
  reg [1:0] rn_q;
  reg       refresh_start;
  always @(posedge clk) begin
    if (!RESETN) begin
      rn_q            <= `BDC_RN_IDLE;
      RENEWAL_REQUEST <= 1'b0;
    end else begin
      case (rn_q)
        `BDC_RN_IDLE: begin
          if (div7) begin
            rn_q            <= `BDC_RN_ASSERT;
            RENEWAL_REQUEST <= 1'b1;
          end
        end
        `BDC_RN_ASSERT: begin
          if (refresh_start) begin
            rn_q            <= `BDC_RN_AWAIT_LOW;
            RENEWAL_REQUEST <= 1'b0;
          end
        end
        `BDC_RN_AWAIT_LOW: begin
          RENEWAL_REQUEST <= 1'b0;
          if (!div7) begin
            rn_q <= `BDC_RN_IDLE;
          end
        end
        default: begin
          rn_q            <= `BDC_RN_IDLE;
          RENEWAL_REQUEST <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Address decode: memory window qualified by the strobe.
  wire mem_access_request = as_q &
       (ADDR[`BDC_WIN_HI:`BDC_WIN_LO] == `BDC_WIN_MATCH);

  // ========================================================================
  // Row/column sequencer.
  reg [2:0] sq_q;
  reg       granted_q;
  reg       col_sel_q;
  reg       burst_sel;
  reg       word_done;
  always @(posedge clk) begin
    if (!RESETN) begin
      sq_q      <= SQ_IDLE;
      granted_q <= 1'b0;
      col_sel_q <= 1'b0;
      RAS_N     <= 4'hF;
      CAS_N     <= 4'hF;
    end else begin
      case (sq_q)
        SQ_IDLE: begin
          col_sel_q <= 1'b0;
          RAS_N     <= 4'hF;
          CAS_N     <= 4'hF;
          if (RENEWAL_REQUEST) begin
            sq_q  <= SQ_RCAS;
            CAS_N <= 4'h0;
          end else if (mem_access_request) begin
            sq_q  <= SQ_RAS;
            RAS_N <= 4'h0;
          end
        end
        SQ_RAS: begin
          col_sel_q <= 1'b1;
          sq_q      <= SQ_MUX;
        end
        SQ_MUX: begin
          granted_q <= 1'b1;
          sq_q      <= SQ_CAS;
          CAS_N     <= rw_q ? 4'h0 : ~lane_mask(SIZE, ADDR[1:0]);
        end
        SQ_CAS: begin
          if (!as_q) begin
            sq_q <= SQ_DONE;
          end else if (word_done) begin
            CAS_N <= 4'hF;
            sq_q  <= SQ_BRST;
          end
        end
        SQ_BRST: begin
          if (!as_q) begin
            sq_q <= SQ_DONE;
          end else if (burst_sel) begin
            CAS_N <= rw_q ? 4'h0 : ~lane_mask(SIZE, ADDR[1:0]);
            sq_q  <= SQ_CAS;
          end
        end
        SQ_RCAS: begin
          RAS_N <= 4'h0;
          sq_q  <= SQ_RRAS;
        end
        SQ_RRAS: begin
          RAS_N <= 4'hF;
          CAS_N <= 4'hF;
          sq_q  <= SQ_IDLE;
        end
        SQ_DONE: begin
          granted_q <= 1'b0;
          col_sel_q <= 1'b0;
          RAS_N     <= 4'hF;
          CAS_N     <= 4'hF;
          sq_q      <= SQ_IDLE;
        end
        default: begin
          sq_q <= SQ_IDLE;
        end
      endcase
    end
  end
  always @* begin
    refresh_start = (sq_q == SQ_IDLE) & RENEWAL_REQUEST;
  end

  // ========================================================================
  // Burst controller: acknowledge, wait states and termination per word.
  reg [1:0] bc_q;
  reg [4:0] wait_q;
  reg [2:0] words_q;
  reg       bsel_q;
  reg       ctr_load;
  reg       ctr_count;
  always @(posedge clk) begin
    if (!RESETN) begin
      bc_q    <= BC_IDLE;
      wait_q  <= 5'h00;
      words_q <= 3'h0;
      bsel_q  <= 1'b0;
      CBACK_N <= 1'b1;
      STERM_N <= 1'b1;
    end else if (!as_q) begin
      bc_q    <= BC_IDLE;
      bsel_q  <= 1'b0;
      CBACK_N <= 1'b1;
      STERM_N <= 1'b1;
    end else begin
      case (bc_q)
        BC_IDLE: begin
          if (granted_q) begin
            bc_q    <= BC_WAIT;
            CBACK_N <= 1'b0;
            wait_q  <= FIRST_CLKS[4:0] - 5'h05;
            words_q <= 3'h0;
          end
        end
        BC_WAIT: begin
          if (wait_q == 5'h00) begin
            STERM_N <= 1'b0;
            bc_q    <= BC_TERM;
          end else begin
            wait_q <= wait_q - 5'h01;
          end
        end
        BC_TERM: begin
          STERM_N <= 1'b1;
          words_q <= words_q + 3'h1;
          if (words_q + 3'h1 == `BDC_WORDS) begin
            bc_q    <= BC_END;
            CBACK_N <= 1'b1;
          end else begin
            bsel_q <= 1'b1;
            wait_q <= NEXT_CLKS[4:0] - 5'h02;
            bc_q   <= BC_WAIT;
          end
        end
        BC_END: begin
          bc_q <= BC_END;
        end
        default: begin
          bc_q <= BC_IDLE;
        end
      endcase
    end
  end
  always @* begin
    word_done = (bc_q == BC_TERM);
    burst_sel = (bc_q == BC_WAIT) & bsel_q & (wait_q == NEXT_CLKS[4:0] - 5'h03);
    ctr_load  = (bc_q == BC_TERM) & (words_q == 3'h0);
    ctr_count = (bc_q == BC_TERM) & (words_q != 3'h0) & (words_q != `BDC_WORDS - 3'h1);
  end

  // ========================================================================
  // Burst address counter for the two low column bits.
  wire [1:0] burst_word;
  bdc_burst_counter u_ctr (
    .clk        (clk),
    .resetn     (RESETN),
    .load       (ctr_load),
    .count      (ctr_count),
    .start_word (ADDR[3:2]),
    .word_q     (burst_word)
  );

  // ========================================================================
  // Address multiplexer: row, then column with burst-supplied low bits.
  always @(posedge clk) begin
    if (!RESETN) begin
      DRAM_ADDR <= 11'h000;
    end else if (!col_sel_q) begin
      DRAM_ADDR <= ADDR[23:13];
    end else if (bsel_q) begin
      DRAM_ADDR <= {ADDR[12:11], ADDR[10:4], burst_word};
    end else begin
      DRAM_ADDR <= {ADDR[12:11], ADDR[10:4], ADDR[3:2]};
    end
  end

  // ========================================================================
  // Watchdog: counts divider bit 7 transitions under a held strobe.
  reg [1:0] wd_q;
  reg [3:0] wd_cnt_q;
  always @(posedge clk) begin
    if (!RESETN) begin
      wd_q     <= WD_IDLE;
      wd_cnt_q <= 4'h0;
      BERR_N   <= 1'b1;
    end else begin
      case (wd_q)
        WD_IDLE: begin
          BERR_N   <= 1'b1;
          wd_cnt_q <= 4'h0;
          if (as_q) begin
            wd_q <= WD_CNT;
          end
        end
        WD_CNT: begin
          if (!as_q) begin
            wd_q <= WD_IDLE;
          end else if (div7_edge) begin
            wd_cnt_q <= wd_cnt_q + 4'h1;
            if (wd_cnt_q + 4'h1 == `BDC_WD_EDGES) begin
              wd_q   <= WD_FLT;
              BERR_N <= 1'b0;
            end
          end
        end
        WD_FLT: begin
          if (!as_q) begin
            BERR_N <= 1'b1;
            wd_q   <= WD_IDLE;
          end
        end
        default: begin
          wd_q <= WD_IDLE;
        end
      endcase
    end
  end
endmodule // bdc_burst_dram_controller
`default_nettype wire

// ==== rtl/bdc_defines.vh ====
// Constants shared by the burst DRAM controller design files.
`ifndef BDC_DEFINES_VH
`define BDC_DEFINES_VH
// ==========================================================================
// Clocking and refresh divider.
`define BDC_CLK_MHZ          25
`define BDC_DIV_WIDTH        8
`define BDC_DIV_TOP          7
// ==========================================================================
// Address map: memory window is address bits 31:24 equal to 8'h01.
`define BDC_WIN_HI           31
`define BDC_WIN_LO           24
`define BDC_WIN_MATCH        8'h01
// ==========================================================================
// Renewal request machine state codes.
`define BDC_RN_IDLE          2'b00
`define BDC_RN_ASSERT        2'b01
`define BDC_RN_AWAIT_LOW     2'b10
// ==========================================================================
// Burst timing: 14 clocks for the first word, 7 for each following word.
`define BDC_FIRST_CLKS       5'h0E
`define BDC_NEXT_CLKS        5'h07
`define BDC_WORDS            3'h4
// Watchdog: nine divider bit 7 transitions give 40.96 to 46.08 usec.
// The first transition can come at any point of a half period, hence nine, not eight.
`define BDC_WD_EDGES         4'h9
`define BDC_DRAM_AW          11
`endif

// ==== verif/bdc_burst_dram_controller_asserts.sv ====
// Port checker for the burst DRAM controller, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module bdc_burst_dram_controller_asserts #(
  parameter FIRST_CLKS = 14,
  parameter NEXT_CLKS  = 7
) (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic [31:0] ADDR,
  input wire logic        AS_N,
  input wire logic        RD_WR,
  input wire logic [1:0]  SIZE,
  input wire logic [3:0]  RAS_N,
  input wire logic [3:0]  CAS_N,
  input wire logic [10:0] DRAM_ADDR,
  input wire logic        CBACK_N,
  input wire logic        STERM_N,
  input wire logic        BERR_N,
  input wire logic        RENEWAL_REQUEST
);
  // ==========================================================================
  // Strobe age counter; it saturates so a stuck strobe never wraps to zero.
  logic [11:0] as_cnt_q;
  logic [11:0] as_cnt_d;
  assign as_cnt_d = AS_N ? 12'h000 : ((&as_cnt_q) ? as_cnt_q : as_cnt_q + 12'h001);
  always_ff @(negedge CLK) begin
    as_cnt_q <= RESETN ? as_cnt_d : 12'h000;
  end
  // ==========================================================================
  // Checks, all on the falling processor clock edge.
  default clocking dcb @(negedge CLK); endclocking
  default disable iff (!RESETN);
  chk_reset_idle_out: assert property ($rose(RESETN) |-> RAS_N == 4'hF && CAS_N == 4'hF
    && CBACK_N && STERM_N && BERR_N && !RENEWAL_REQUEST) else $error("outputs busy after reset");
  chk_sterm_one_pulse: assert property ($fell(STERM_N) |=> STERM_N [*5])
    else $error("termination pulse too long or too close");
  chk_refresh_all_lines: assert property ((CAS_N != 4'hF) && ($past(CAS_N) == 4'hF)
    && (RAS_N == 4'hF) |-> CAS_N == 4'h0 ##1 RAS_N == 4'h0) else $error("refresh strobes wrong");
  chk_request_drop: assert property ((CAS_N == 4'h0) && (RAS_N == 4'hF)
    |-> ##[0:2] !RENEWAL_REQUEST) else $error("refresh request not dropped");
  chk_request_once: assert property ($fell(RENEWAL_REQUEST) |=> !RENEWAL_REQUEST [*8])
    else $error("refresh request raised again too soon");
  chk_row_then_col: assert property ($fell(RAS_N[0]) && CAS_N == 4'hF
    |=> CAS_N == 4'hF ##[1:2] CAS_N != 4'hF) else $error("column strobe order wrong");
  chk_decode_window: assert property ($fell(RAS_N[0]) && CAS_N == 4'hF
    |-> ADDR[31:24] == 8'h01 && !AS_N) else $error("row strobe outside window");
  chk_row_address: assert property ($fell(RAS_N[0]) && CAS_N == 4'hF
    |-> DRAM_ADDR == ADDR[23:13]) else $error("row address wrong at row strobe");
  chk_ack_after_grant: assert property ($fell(RAS_N[0]) && CAS_N == 4'hF
    |-> ##[1:4] !CBACK_N) else $error("burst acknowledge missing");
  chk_row_held_burst: assert property (!CBACK_N |-> RAS_N != 4'hF)
    else $error("row strobe dropped in burst");
  chk_berr_holds: assert property (!BERR_N && !AS_N |=> !BERR_N)
    else $error("bus error released early");
  chk_strobe_clears: assert property ($rose(AS_N) |-> ##[1:4] (BERR_N && CBACK_N && STERM_N))
    else $error("outputs not cleared after strobe");
  chk_berr_window: assert property ($fell(BERR_N) |-> as_cnt_q >= 12'h3FC
    && as_cnt_q <= 12'h488) else $error("bus error outside timeout window");
endmodule // bdc_burst_dram_controller_asserts
bind bdc_burst_dram_controller bdc_burst_dram_controller_asserts #(
  .FIRST_CLKS(FIRST_CLKS), .NEXT_CLKS(NEXT_CLKS)) bdc_chk_inst (.CLK(CLK), .RESETN(RESETN),
  .ADDR(ADDR), .AS_N(AS_N), .RD_WR(RD_WR), .SIZE(SIZE), .RAS_N(RAS_N), .CAS_N(CAS_N),
  .DRAM_ADDR(DRAM_ADDR), .CBACK_N(CBACK_N), .STERM_N(STERM_N), .BERR_N(BERR_N),
  .RENEWAL_REQUEST(RENEWAL_REQUEST));
`default_nettype wire

// ==== verif/bdc_cpu_model.sv ====
// Behavioural processor bus master that runs one access per start pulse.
`timescale 1ns/10ps
`default_nettype none
module bdc_cpu_model (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [31:0] addr_in,
  input  wire logic        rd_in,
  input  wire logic [1:0]  size_in,
  input  wire logic [2:0]  words,
  input  wire logic [11:0] limit,
  input  wire logic        sterm_n,
  input  wire logic        berr_n,
  output var  logic        as_n,
  output var  logic [31:0] addr,
  output var  logic        rd_wr,
  output var  logic [1:0]  size,
  output var  logic        busy,
  output var  logic        berr_seen
);
  logic [2:0]  got;
  logic [11:0] age;
  logic [2:0]  gap;
  initial begin
    {as_n, addr, rd_wr, size, busy, berr_seen, got, age, gap} = {1'b1, 32'h0, 1'b1, 22'h0};
  end
  // ==========================================================================
  // Bus cycle. Outputs move on the processor clock's rising edge, half a period before the controller samples them.
  always @(posedge clk) begin
    if (!busy) begin
      if (start) begin
        {busy, as_n, addr, rd_wr, size} <= {2'b10, addr_in, rd_in, size_in};
        {got, age, gap, berr_seen} <= 19'h0;
      end
    end else if (!as_n) begin
      age <= age + 12'h001;
      got <= got + {2'h0, !sterm_n};
      berr_seen <= berr_seen | !berr_n;
      // Strobe is held until the last termination, a bus error or the age limit is seen.
      if (!berr_n || (!sterm_n && got + 3'h1 == words) || age == limit) begin
        as_n <= 1'b1;
        addr <= ~addr;
      end
    end else begin
      // Idle gap so the sequencer is back in idle before the next access.
      gap <= gap + 3'h1;
      if (gap == 3'h7) busy <= 1'b0;
    end
  end
endmodule // bdc_cpu_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking testbench for the burst DRAM controller.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk_n = 1'b0;
  logic        resetn = 1'b0;
  logic        start = 1'b0;
  logic [31:0] a_in = 32'h0;
  logic        rd_in = 1'b1;
  logic [1:0]  sz_in = 2'h0;
  logic [2:0]  wds = 3'h4;
  logic [11:0] lim = 12'hFFF;
  logic        as_n, rd_wr, busy, berr_seen, cback_n, sterm_n, berr_n, renewal, prev;
  logic [31:0] addr;
  logic [1:0]  size;
  logic [3:0]  ras_n, cas_n;
  logic [3:0]  cas_prev = 4'hF;
  logic [10:0] dram_addr;
  logic [14:0] notes[$];
  int          failures = 0;
  int          check_count = 0;
  int          n, k, rises;
  always #5 clk_n = ~clk_n;
  bdc_burst_dram_controller bdc_burst_dram_controller_inst (.CLK(clk_n), .RESETN(resetn),
    .ADDR(addr), .AS_N(as_n), .RD_WR(rd_wr), .SIZE(size), .RAS_N(ras_n), .CAS_N(cas_n),
    .DRAM_ADDR(dram_addr), .CBACK_N(cback_n), .STERM_N(sterm_n), .BERR_N(berr_n),
    .RENEWAL_REQUEST(renewal));
  bdc_cpu_model bdc_cpu_model_inst (.clk(clk_n), .start(start), .addr_in(a_in), .rd_in(rd_in),
    .size_in(sz_in), .words(wds), .limit(lim), .sterm_n(sterm_n), .berr_n(berr_n), .as_n(as_n),
    .addr(addr), .rd_wr(rd_wr), .size(size), .busy(busy), .berr_seen(berr_seen));
  // ==========================================================================
  // Shared comparison, verdict and access tasks.
  task automatic check(input logic [14:0] seen, input logic [14:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Notes the lanes and column of every expected word, then runs one access.
  task automatic acc(input logic [31:0] a, input logic r, input logic [1:0] sz,
                     input logic [2:0] w, input logic [11:0] l);
    logic [3:0] m;
    m = 4'hF;
    for (int b = a[1:0]; b < a[1:0] + (sz == 2'h0 ? 4 : sz) && b < 4; b++) m[b] = 1'b0;
    if (r) m = 4'h0;
    for (int j = 0; j < w && a[31:24] == 8'h01; j++) notes.push_back({m, a[12:4], 2'(a[3:2] + j)});
    @(posedge clk_n);
    {start, a_in, rd_in, sz_in, wds, lim} <= {1'b1, a, r, sz, w, l};
    @(posedge clk_n);
    start <= 1'b0;
    repeat (2) @(negedge clk_n);
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk_n);
  endtask
  // ==========================================================================
  // Monitor: each new column strobe of an access takes the oldest note.
  always @(posedge clk_n) begin
    if (resetn && cas_n != 4'hF && cas_prev == 4'hF && ras_n != 4'hF) begin
      if (notes.size() == 0) check(15'h7FFF, 15'h0, "unexpected column strobe");
      else check({cas_n, dram_addr}, notes.pop_front(), "column strobe");
    end
    cas_prev = cas_n;
  end
  // ==========================================================================
  // Watchdog, sized well above the expected run of about 3400 cycles.
  initial begin
    repeat (20000) @(posedge clk_n);
    failures++;
    $display("wrong value at %0t: run did not finish", $time);
    final_report();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(32'h5e3b));
    repeat (10) @(posedge clk_n);
    resetn <= 1'b1;
    @(posedge clk_n);
    prev = renewal;
    rises = 0;
    repeat (1024) begin
      @(posedge clk_n);
      rises += (renewal === 1'b1 && prev === 1'b0);
      prev = renewal;
    end
    check(15'(rises), 15'h4, "refresh requests");
    $display("test refresh cadence done");
    for (k = 0; k < 4; k++) acc({8'h01, 20'($urandom), 2'(k), 2'h0}, 1'b1, 2'($urandom), 3'h4, 12'hFFF);
    check(15'(notes.size()), 15'h0, "burst words missing");
    $display("test burst reads done");
    for (k = 0; k < 16; k++) acc({8'h01, 20'($urandom), 2'($urandom), 2'(k)}, 1'b0, 2'(k >> 2), 3'h1, 12'hFFF);
    check(15'(notes.size()), 15'h0, "write words missing");
    $display("test byte lane writes done");
    acc({8'h01, 24'($urandom)} & 32'hFFFFFFFC, 1'b1, 2'h0, 3'h2, 12'hFFF);
    acc({8'h01, 24'($urandom)} & 32'hFFFFFFFC, 1'b1, 2'h0, 3'h4, 12'hFFF);
    check(15'(notes.size()), 15'h0, "short burst recovery");
    $display("test short burst done");
    acc({8'h02, 24'($urandom)}, 1'b1, 2'h0, 3'h0, 12'h1F4);
    check({14'h0, berr_seen}, 15'h0, "early negation bus error");
    acc({8'hA5, 24'($urandom)}, 1'b1, 2'h0, 3'h0, 12'hFFF);
    check({14'h0, berr_seen}, 15'h1, "timeout bus error");
    check({12'h0, berr_n, cback_n, sterm_n}, 15'h7, "outputs after negation");
    $display("test bus error done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
